// ===== logic/dasp_pkg.sv
// Constants and types shared by both ends of the two-wire slave port
// How it works
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - SDA changes only while SCL low
// - Device drives bit at preceding SCL fall
// - Ninth bit from receiver: 0 ack
// - Bytes travel most significant bit first
// - Master acks reads, nacks the last
// - First byte: seven address bits, direction
// - Direction 0 writes, 1 reads
// - Aux at A0h, off if main A0h/B0h
// - Main address low bits from config
// - Main address needs select enable set
// - Unmatched address: ignore until next start
// - Second write byte sets memory location
// - Single write: start, addr, loc, data, stop
// - One to eight data bytes, counter advances
// - Write counter wraps inside 8-byte row
// - Part and revision read-only identifiers
// - Reads start at current counter value
// - Nack own address during row write
package dasp_pkg;
    // ************************************************************
    // Register map of the device
    // ************************************************************
    localparam logic [7:0] PART_IDENTIFIER_OFF         = 8'h86;
    localparam logic [7:0] REVISION_IDENTIFIER_OFF     = 8'h87;
    localparam logic [7:0] CTL_OFF                     = 8'h88;
    localparam logic [7:0] MAIN_BUS_ADDRESS_SELECT_OFF = 8'h8b;
    localparam int         ADDRESS_SELECT_ENABLE_BIT   = 0;
    localparam logic [7:0] CTL_RST                     = 8'h00;
    localparam logic [7:0] MAIN_BUS_ADDRESS_SELECT_RST = 8'h00;
    // Arbitrary identity values
    localparam logic [7:0] PART_ID      = 8'h5a;
    localparam logic [7:0] REV_ID       = 8'h01;
    // ************************************************************
    // Bus addresses
    // ************************************************************
    localparam logic [7:0] AUX_ADDR     = 8'ha0;
    localparam logic [7:0] AUX_ALT      = 8'hb0;
    localparam logic [7:0] DEF_MAIN     = 8'ha2;
    localparam logic [2:0] MAIN_TOP     = 3'h5;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS       = 10;
    localparam int WR_TIME_NS   = 100000;
    localparam int WR_CYC       = WR_TIME_NS / CLK_NS;
    // Short quarter keeps a full register walk within the run budget
    localparam int SCL_QTR_NS   = 1250;
    localparam int SCL_QTR_CYC  = SCL_QTR_NS / CLK_NS;
    // ************************************************************
    // Host registers (byte addresses)
    // ************************************************************
    localparam logic [3:0] H_CMD_OFF    = 4'h0;
    localparam logic [3:0] H_STAT_OFF   = 4'h4;
    localparam logic [3:0] H_RX_OFF     = 4'h8;
    localparam logic [1:0] OP_START     = 2'h1;
    localparam logic [1:0] OP_STOP      = 2'h2;
    localparam logic [1:0] OP_BYTE      = 2'h3;
    localparam int         CMD_READ_BIT = 2;
    localparam int         CMD_NACK_BIT = 3;
    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RX    = 3'h1,
        ST_RXACK = 3'h3,
        ST_TX    = 3'h2,
        ST_TXACK = 3'h6
    } dasp_dev_e;
    typedef enum logic [1:0] {
        H_IDLE  = 2'h0,
        H_START = 2'h1,
        H_BIT   = 2'h3,
        H_STOP  = 2'h2
    } dasp_host_e;
endpackage : dasp_pkg

// ===== logic/dasp_if.sv
// Open-drain two-wire link joining master and slave port
`timescale 1ns/10ps
interface dasp_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;
    // Wired-and with pull-ups
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
    modport dev  (input scl, sda, output d_sda_o, d_sda_oe);
    modport host (input scl, sda, output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe);
endinterface : dasp_if

// ===== logic/dasp_dev.sv
// Slave end: bit engine, address match, row-limited memory writes
//
`timescale 1ns/10ps
module dasp_dev
    import dasp_pkg::*;
#(
    parameter int WR_CYCLES = WR_CYC
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_B,
    // Link
    dasp_if.dev             LINK,
    // Status
    output logic            BUSY,
    output logic [7:0]      MAIN_ADDR
);
    // ************************************************************
    // Pin synchronisers and edge detect
    // ************************************************************
    logic [2:0] scl_q;
    logic [2:0] sda_q;

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], LINK.scl};
            sda_q <= {sda_q[1:0], LINK.sda};
        end
    end

    wire scl_rise  = scl_q[1] & ~scl_q[2];
    wire scl_fall  = ~scl_q[1] & scl_q[2];
    wire scl_hi    = scl_q[1] & scl_q[2];
    wire start_det = scl_hi & ~sda_q[1] & sda_q[2];
    wire stop_det  = scl_hi & sda_q[1] & ~sda_q[2];

    // ************************************************************
    // State
    // ************************************************************
    dasp_dev_e   state;
    logic [3:0]  rxcnt;
    logic [2:0]  txcnt;
    logic [1:0]  idx;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  ptr;
    logic        sel_aux;
    logic        rw;
    logic        ack_ok;
    logic        sda_low;
    logic        dirty;
    logic [23:0] busy_cnt;
    logic [7:0]  ctl_reg;
    logic [7:0]  main_bus_address_select;
    logic [7:0]  main_mem [0:255];
    logic [7:0]  aux_mem  [0:255];

    // ************************************************************
    // Address decode
    // ************************************************************
    wire [7:0] main_addr = ctl_reg[ADDRESS_SELECT_ENABLE_BIT] ?
                           {MAIN_TOP, main_bus_address_select[4:1], 1'b0} :
                           DEF_MAIN;
    wire       aux_en    = (main_addr != AUX_ADDR) && (main_addr != AUX_ALT);
    wire       hit_main  = rx_sh[7:1] == main_addr[7:1];
    wire       hit_aux   = aux_en && (rx_sh[7:1] == AUX_ADDR[7:1]);
    wire       busy      = busy_cnt != 24'h0;
    wire       byte_end  = (state == ST_RX) && scl_fall && (rxcnt == 4'h8);
    wire       wr_fire   = byte_end && (idx == 2'h2) && !rw;
    wire [7:0] ptr_row   = {ptr[7:3], ptr[2:0] + 3'h1};
    wire [7:0] ptr_next  = ptr + 8'h1;
    wire       cfg_hit   = (ptr == CTL_OFF) || (ptr == MAIN_BUS_ADDRESS_SELECT_OFF) ||
                           (ptr == PART_IDENTIFIER_OFF) || (ptr == REVISION_IDENTIFIER_OFF);

    // Read mux; identifiers are constants
    wire [7:0] rd_main   = (ptr == PART_IDENTIFIER_OFF)         ? PART_ID :
                           (ptr == REVISION_IDENTIFIER_OFF)     ? REV_ID :
                           (ptr == CTL_OFF)                     ? ctl_reg :
                           (ptr == MAIN_BUS_ADDRESS_SELECT_OFF) ? main_bus_address_select :
                           main_mem[ptr];
    wire [7:0] rd_data   = sel_aux ? aux_mem[ptr] : rd_main;

    // ************************************************************
    // Memory arrays; contents carry no reset
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (wr_fire && sel_aux) begin
            aux_mem[ptr] <= rx_sh;
        end
        if (wr_fire && !sel_aux && !cfg_hit) begin
            main_mem[ptr] <= rx_sh;
        end
    end

    // ************************************************************
    // Protocol engine
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state    <= ST_IDLE;
            rxcnt    <= 4'h0;
            txcnt    <= 3'h0;
            idx      <= 2'h0;
            rx_sh    <= 8'h00;
            tx_sh    <= 8'h00;
            ptr      <= 8'h00;
            sel_aux  <= 1'b0;
            rw       <= 1'b0;
            ack_ok   <= 1'b0;
            sda_low  <= 1'b0;
            dirty    <= 1'b0;
            busy_cnt <= 24'h0;
            ctl_reg  <= CTL_RST;
            main_bus_address_select <= MAIN_BUS_ADDRESS_SELECT_RST;
        end else if (start_det) begin
            // Also serves as repeated start
            state   <= ST_RX;
            rxcnt   <= 4'h0;
            idx     <= 2'h0;
            sda_low <= 1'b0;
        end else if (stop_det) begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
            dirty   <= 1'b0;
            if (dirty) begin
                busy_cnt <= 24'(WR_CYCLES);
            end
        end else begin
            if (busy) begin
                busy_cnt <= busy_cnt - 24'h1;
            end
            case (state)
                ST_IDLE: begin
                    sda_low <= 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh <= {rx_sh[6:0], sda_q[1]};
                        rxcnt <= rxcnt + 4'h1;
                    end else if (byte_end) begin
                        rxcnt <= 4'h0;
                        if (idx == 2'h0) begin
                            if ((hit_main || hit_aux) && !busy) begin
                                sel_aux <= hit_aux && !hit_main;
                                rw      <= rx_sh[0];
                                idx     <= 2'h1;
                                sda_low <= 1'b1;
                                state   <= ST_RXACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else if (idx == 2'h1) begin
                            ptr     <= rx_sh;
                            idx     <= 2'h2;
                            sda_low <= 1'b1;
                            state   <= ST_RXACK;
                        end else begin
                            ptr     <= ptr_row;
                            dirty   <= 1'b1;
                            sda_low <= 1'b1;
                            state   <= ST_RXACK;
                            if (!sel_aux && ptr == CTL_OFF) begin
                                ctl_reg <= rx_sh;
                            end
                            if (!sel_aux && ptr == MAIN_BUS_ADDRESS_SELECT_OFF) begin
                                main_bus_address_select <= rx_sh;
                            end
                        end
                    end
                end
                ST_RXACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            tx_sh   <= rd_data;
                            sda_low <= ~rd_data[7];
                            txcnt   <= 3'h0;
                            state   <= ST_TX;
                        end else begin
                            sda_low <= 1'b0;
                            state   <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (txcnt == 3'h7) begin
                            sda_low <= 1'b0;
                            ptr     <= ptr_next;
                            state   <= ST_TXACK;
                        end else begin
                            txcnt   <= txcnt + 3'h1;
                            tx_sh   <= {tx_sh[6:0], 1'b0};
                            sda_low <= ~tx_sh[6];
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        ack_ok <= ~sda_q[1];
                    end else if (scl_fall) begin
                        if (ack_ok) begin
                            tx_sh   <= rd_data;
                            sda_low <= ~rd_data[7];
                            txcnt   <= 3'h0;
                            state   <= ST_TX;
                        end else begin
                            sda_low <= 1'b0;
                            state   <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state   <= ST_IDLE;
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            BUSY      <= 1'b0;
            MAIN_ADDR <= DEF_MAIN;
        end else begin
            BUSY      <= busy;
            MAIN_ADDR <= main_addr;
        end
    end

    // Open drain: only ever pulls low
    assign LINK.d_sda_o  = 1'b0;
    assign LINK.d_sda_oe = sda_low;
endmodule : dasp_dev

// ===== logic/dasp_host.sv
// Master end: Avalon-MM command registers driving start, stop and byte cycles
`timescale 1ns/10ps
module dasp_host
    import dasp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Link
    dasp_if.host             LINK
);
    dasp_host_e  state;
    logic [1:0]  phase;
    logic [15:0] qcnt;
    logic [3:0]  bitcnt;
    logic [8:0]  tx_sh;
    logic [8:0]  rx_sh;
    logic [7:0]  rx_data;
    logic        nack;
    logic        scl_low;
    logic        sda_low;
    logic        rd_done;
    logic [1:0]  sda_q;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire busy    = state != H_IDLE;
    wire cmd_sel = AVS_ADDRESS == H_CMD_OFF;
    wire cmd_go  = AVS_WRITE && cmd_sel && !busy;
    wire tick    = qcnt == 16'(SCL_QTR_CYC - 1);
    wire [1:0] op = AVS_WRITEDATA[1:0];
    // Write carries data then a released ack; read releases data then sends the nack bit as its ack
    wire [8:0] tx_load = AVS_WRITEDATA[CMD_READ_BIT] ?
                         {8'hff, AVS_WRITEDATA[CMD_NACK_BIT]} :
                         {AVS_WRITEDATA[15:8], 1'b1};
    wire [31:0] rd_mux = (AVS_ADDRESS == H_STAT_OFF) ? {30'h0, nack, busy} :
                         (AVS_ADDRESS == H_RX_OFF)   ? {24'h0, rx_data} :
                         32'h0;

    assign AVS_WAITREQUEST = (AVS_READ && !rd_done) || (AVS_WRITE && cmd_sel && busy);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rd_done      <= 1'b0;
            AVS_READDATA <= 32'h0;
        end else begin
            rd_done      <= AVS_READ && !rd_done;
            AVS_READDATA <= rd_mux;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sda_q <= 2'h3;
        end else begin
            sda_q <= {sda_q[0], LINK.sda};
        end
    end

    // ************************************************************
    // Quarter-period sequencer
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state   <= H_IDLE;
            phase   <= 2'h0;
            qcnt    <= 16'h0;
            bitcnt  <= 4'h0;
            tx_sh   <= 9'h1ff;
            rx_sh   <= 9'h0;
            rx_data <= 8'h00;
            nack    <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else if (cmd_go) begin
            qcnt   <= 16'h0;
            phase  <= 2'h0;
            bitcnt <= 4'h0;
            tx_sh  <= tx_load;
            case (op)
                OP_START: state <= H_START;
                OP_STOP:  state <= H_STOP;
                OP_BYTE:  state <= H_BIT;
                default:  state <= H_IDLE;
            endcase
        end else if (busy) begin
            qcnt <= tick ? 16'h0 : qcnt + 16'h1;
            if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    H_START: begin
                        case (phase)
                            2'h0: sda_low <= 1'b0;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b1;
                            default: begin
                                scl_low <= 1'b1;
                                state   <= H_IDLE;
                            end
                        endcase
                    end
                    H_STOP: begin
                        case (phase)
                            2'h0: sda_low <= 1'b1;
                            2'h1: scl_low <= 1'b0;
                            2'h2: sda_low <= 1'b0;
                            default: state <= H_IDLE;
                        endcase
                    end
                    H_BIT: begin
                        case (phase)
                            2'h0: sda_low <= ~tx_sh[8];
                            2'h1: scl_low <= 1'b0;
                            2'h2: rx_sh   <= {rx_sh[7:0], sda_q[1]};
                            default: begin
                                scl_low <= 1'b1;
                                tx_sh   <= {tx_sh[7:0], 1'b1};
                                bitcnt  <= bitcnt + 4'h1;
                                if (bitcnt == 4'h8) begin
                                    rx_data <= rx_sh[8:1];
                                    nack    <= rx_sh[0];
                                    sda_low <= 1'b0;
                                    state   <= H_IDLE;
                                end
                            end
                        endcase
                    end
                    default: state <= H_IDLE;
                endcase
            end
        end
    end

    assign LINK.m_scl_o  = 1'b0;
    assign LINK.m_scl_oe = scl_low;
    assign LINK.m_sda_o  = 1'b0;
    assign LINK.m_sda_oe = sda_low;
endmodule : dasp_host

// ===== verif/dasp_assertions.sv
// Checker watching the shared two-wire link between both ends
`timescale 1ns/10ps
module dasp_assertions
    import dasp_pkg::*;
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST_B,
    // Link lines and enables
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic m_sda_oe,
    input  wire logic d_sda_oe,
    // Device status
    input  wire logic busy
);
    // ************************************************************
    // Bus tracker
    // ************************************************************
    logic       scl_q;
    logic       sda_q;
    logic       framed;
    logic       first;
    logic       wr;
    logic       hit_q;
    logic [9:0] lo_cnt;
    logic [7:0] sh;
    logic [3:0] cnt;
    wire        rise  = scl & ~scl_q;
    wire        start = scl & scl_q & sda_q & ~sda;
    wire        stop  = scl & scl_q & ~sda_q & sda;
    // Assumes the main address stays at its default
    wire        hit_c = (sh[7:1] == DEF_MAIN[7:1]) | (sh[7:1] == AUX_ADDR[7:1]);

    always_ff @(posedge CLK) begin
        scl_q  <= scl;
        sda_q  <= sda;
        lo_cnt <= scl ? 10'h0 : lo_cnt + {9'h0, lo_cnt != 10'h3ff};
        if (!RST_B) begin
            framed <= 1'b0;
            first  <= 1'b0;
            cnt    <= 4'h0;
        end else if (start) begin
            framed <= 1'b1;
            first  <= 1'b1;
            cnt    <= 4'h0;
        end else if (stop) begin
            framed <= 1'b0;
        end else if (rise) begin
            sh  <= {sh[6:0], sda};
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            if (cnt == 4'h8) begin
                first <= 1'b0;
            end
            if (cnt == 4'h8 && first) begin
                hit_q <= hit_c;
                wr    <= ~sh[0];
            end
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    chk_dev_fall_edge: assert property (@(posedge CLK) disable iff (!RST_B)
        $changed(d_sda_oe) |-> !scl && lo_cnt < 10'd12) else $error("device enable moved off scl fall");
    chk_dev_hold_high: assert property (@(posedge CLK) disable iff (!RST_B)
        scl && scl_q |-> $stable(d_sda_oe)) else $error("device enable moved while scl high");
    chk_dev_quiet_idle: assert property (@(posedge CLK) disable iff (!RST_B)
        !framed |-> !d_sda_oe) else $error("device drives idle bus");
    chk_scl_low_len: assert property (@(posedge CLK) disable iff (!RST_B)
        rise |-> lo_cnt >= 10'(2 * SCL_QTR_CYC - 5)) else $error("scl low phase too short");
    chk_host_edge_setup: assert property (@(posedge CLK) disable iff (!RST_B)
        $changed(m_sda_oe) && scl |-> $past(scl, 100)) else $error("master sda edge without scl high");
    chk_addr_ignore: assert property (@(posedge CLK) disable iff (!RST_B)
        first && cnt == 4'h8 && !hit_c |-> !d_sda_oe) else $error("foreign address answered");
    chk_addr_ack: assert property (@(posedge CLK) disable iff (!RST_B)
        rise && first && cnt == 4'h8 && hit_c && !busy |-> d_sda_oe) else $error("own address not acked");
    chk_data_ack: assert property (@(posedge CLK) disable iff (!RST_B)
        rise && !first && cnt == 4'h8 && framed && wr && hit_q |-> d_sda_oe) else $error("data not acked");
    chk_read_release: assert property (@(posedge CLK) disable iff (!RST_B)
        rise && !first && cnt == 4'h8 && framed && !wr && hit_q |-> !d_sda_oe) else $error("ack slot held");
endmodule : dasp_assertions

// ===== verif/testbench.sv
// Self-checking bench joining master and slave ends over the link
`timescale 1ns/10ps
module testbench
    import dasp_pkg::*;
;
    logic        CLK   = 1'b0;
    logic        RST_B = 1'b0;
    logic [3:0]  addr  = 4'h0;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wd    = 32'h0;
    logic [31:0] q;
    logic [31:0] rdat;
    logic        wreq;
    logic        busy;
    logic [7:0]  main_a;
    int          n_mismatch = 0;
    int          compares   = 0;
    int          n;
    always #5 CLK = ~CLK;
    dasp_if i_dasp_if ();
    // Short row-write time keeps the busy window visible
    dasp_dev #(.WR_CYCLES(50)) i_dasp_dev (.CLK(CLK), .RST_B(RST_B), .LINK(i_dasp_if), .BUSY(busy),
        .MAIN_ADDR(main_a));
    dasp_host i_dasp_host (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .LINK(i_dasp_if));
    dasp_assertions i_dasp_assertions (.CLK(CLK), .RST_B(RST_B), .scl(i_dasp_if.scl), .sda(i_dasp_if.sda),
        .m_sda_oe(i_dasp_if.m_sda_oe), .d_sda_oe(i_dasp_if.d_sda_oe), .busy(busy));
    // ************************************************************
    // Tasks
    // ************************************************************
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task report_and_stop;
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // One Avalon transfer, held until waitrequest is sampled low
    task av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK);
        addr <= a;
        wd   <= d;
        wr   <= w;
        rd   <= !w;
        for (k = 0; k < 20000; k++) begin
            @(posedge CLK);
            if (wreq === 1'b0) break;
        end
        q = rdat;
        if (k == 20000) begin
            n_mismatch++;
            report_and_stop;
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av
    task op(input logic [1:0] o, input logic r, input logic nk, input logic [7:0] d);
        av(1'b1, H_CMD_OFF, {16'h0, d, 4'h0, nk, r, o});
    endtask : op
    task wait_idle;
        int k;
        for (k = 0; k < 6000; k++) begin
            av(1'b0, H_STAT_OFF, 32'h0);
            if (q[0] === 1'b0) break;
        end
        if (k == 6000) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask : wait_idle
    task xfer(input logic r, input logic nk, input logic [7:0] d, input logic ack_bit, input string what);
        op(OP_BYTE, r, nk, d);
        wait_idle;
        check(what, {31'h0, q[1]}, {31'h0, ack_bit});
    endtask : xfer
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK);
        check("main address", {24'h0, main_a}, {24'h0, DEF_MAIN});
        av(1'b0, 4'hc, 32'h0);
        check("unmapped read", q, 32'h0);
        $display("Test reset state done");
        // Row wrap: 07h then 00h
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, DEF_MAIN, 1'b0, "write address ack");
        xfer(1'b0, 1'b0, 8'h07, 1'b0, "location ack");
        xfer(1'b0, 1'b0, 8'h11, 1'b0, "data ack");
        xfer(1'b0, 1'b0, 8'h22, 1'b0, "wrapped data ack");
        op(OP_STOP, 1'b0, 1'b0, 8'h0);
        for (n = 0; n < 3000 && busy !== 1'b1; n++) @(posedge CLK);
        check("row write starts", {31'h0, busy}, 32'h1);
        for (n = 0; n < 200 && busy === 1'b1; n++) @(posedge CLK);
        check("row write time", {31'h0, n >= 49 && n <= 51}, 32'h1);
        $display("Test row write wrap done");
        // Dummy write to 00h, repeated start, single read
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, DEF_MAIN, 1'b0, "address ack");
        xfer(1'b0, 1'b0, 8'h00, 1'b0, "pointer ack");
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, DEF_MAIN | 8'h01, 1'b0, "read address ack");
        xfer(1'b1, 1'b1, 8'hff, 1'b1, "last read nack");
        av(1'b0, H_RX_OFF, 32'h0);
        check("wrapped byte", {24'h0, q[7:0]}, 32'h22);
        op(OP_STOP, 1'b0, 1'b0, 8'h0);
        $display("Test read back done");
        // Foreign address is ignored
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, 8'ha4, 1'b1, "foreign address nack");
        op(OP_STOP, 1'b0, 1'b0, 8'h0);
        wait_idle;
        $display("Test foreign address done");
        // Identifiers through a dummy write, then the aux address
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, DEF_MAIN, 1'b0, "id address ack");
        xfer(1'b0, 1'b0, PART_IDENTIFIER_OFF, 1'b0, "id pointer ack");
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, DEF_MAIN | 8'h01, 1'b0, "id read address ack");
        xfer(1'b1, 1'b0, 8'hff, 1'b0, "first read ack");
        av(1'b0, H_RX_OFF, 32'h0);
        check("part identifier", {24'h0, q[7:0]}, {24'h0, PART_ID});
        xfer(1'b1, 1'b1, 8'hff, 1'b1, "second read nack");
        av(1'b0, H_RX_OFF, 32'h0);
        check("revision identifier", {24'h0, q[7:0]}, {24'h0, REV_ID});
        op(OP_STOP, 1'b0, 1'b0, 8'h0);
        $display("Test identifiers done");
        op(OP_START, 1'b0, 1'b0, 8'h0);
        xfer(1'b0, 1'b0, AUX_ADDR, 1'b0, "aux address ack");
        op(OP_STOP, 1'b0, 1'b0, 8'h0);
        wait_idle;
        $display("Test aux address done");
        report_and_stop;
    end
endmodule : testbench
